/* sswd_pkg.sv */
package sswd_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Time base
  localparam int unsigned CLK_KHZ       = 250000;  // System clock rate
  localparam int unsigned CLK_PERIOD_NS = 4;       // System clock period
  localparam int unsigned RST_TIMEOUT_MS = 200;    // Nominal reset hold
  localparam int unsigned RST_TICKS     = 2048;    // Ticks per reset hold
  // Internal oscillator tick, derived so that 2048 ticks give 200 ms
  localparam int unsigned INT_TICK_CYC  = (RST_TIMEOUT_MS * CLK_KHZ) / RST_TICKS;
  localparam int unsigned CE_GRACE_NS   = 15000;   // Select grace window
  localparam int unsigned CE_GRACE_CYC  = CE_GRACE_NS / CLK_PERIOD_NS;

  // Last tick index of each period (count minus one)
  localparam logic [11:0] RST_LAST         = 12'(RST_TICKS - 1);
  localparam logic [14:0] WD_FAST_LAST     = 15'h03FF;  // 1024 ticks
  localparam logic [14:0] WD_EXT_SLOW_LAST = 15'h0FFF;  // 4096 ticks
  localparam logic [14:0] WD_INT_SLOW_LAST = 15'h3FFF;  // 16384 ticks, 1.6 s
  localparam logic [11:0] CE_GRACE_LAST    = 12'(CE_GRACE_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int unsigned ADDR_W   = 4;
  localparam logic [3:0] OFS_CTRL  = 4'h0;  // Watchdog enable
  localparam logic [3:0] OFS_STAT  = 4'h4;  // Live state, read only
  localparam logic [3:0] OFS_ISTAT = 4'h8;  // Sticky events, write 1 clears
  localparam logic [3:0] OFS_IMASK = 4'hC;  // Interrupt mask
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int unsigned EV_WD = 0;  // Watchdog timeout event
  localparam int unsigned EV_SL = 1;  // Supply dropped event
  localparam int unsigned EV_PF = 2;  // Power-fail fell event

  ////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    ST_LOW  = 3'b001,  // Supply below threshold
    ST_HOLD = 3'b010,  // Reset timeout running
    ST_RUN  = 3'b100   // Normal operation
  } sswd_fsm_type;

  // Supervised inputs, analog levels already compared
  typedef struct packed {
    logic supply_ok;          // Main supply above reset threshold
    logic main_above_backup;  // Main supply above backup_supply_in
    logic activity_mid;       // activity_in at undriven mid level
    logic activity_lvl;       // activity_in logic level
    logic timing_source_sel;  // High or undriven: internal oscillator
    logic timing_osc_pin;     // Oscillator pin level or clock
    logic powerfail_below;    // powerfail_sense_in below 1.25 V
    logic mem_sel_n;          // Memory select input
  } sswd_pins_in_type;

  // Supervisor outputs
  typedef struct packed {
    logic reset_n;                  // Active-low reset
    logic reset;                    // Active-high reset
    logic low_supply_n;             // Low-supply flag
    logic battery_on_flag;          // Backup source in use
    logic switched_supply_out;      // 1: from backup, 0: from main
    logic activity_timeout_flag_n;  // Watchdog flag
    logic powerfail_flag_n;         // Power-fail flag
    logic mem_sel_out_n;            // Gated memory select
  } sswd_pins_out_type;

  // Whole module state
  typedef struct packed {
    sswd_fsm_type st;
    logic [14:0]  pre;
    logic         osc_q;
    logic         act_q;
    logic [14:0]  wd_cnt;
    logic         first;
    logic [11:0]  rst_cnt;
    logic         rsto_n;
    logic         wdo_n;
    logic         batt;
    logic         ce_n;
    logic         grace;
    logic [11:0]  gcnt;
    logic         low_n;
    logic         pf_n;
    logic         wd_en;
    logic [2:0]   ist;
    logic [2:0]   imask;
    logic         aw_have;
    logic [3:0]   awaddr;
    logic         w_have;
    logic [7:0]   wdata;
    logic         wstrb0;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [1:0]   rresp;
    logic [31:0]  rdata;
  } sswd_regs_type;

  localparam sswd_regs_type REGS_RST = '{st: ST_LOW, wdo_n: 1'b1, ce_n: 1'b1,
                                         pf_n: 1'b1, wd_en: 1'b1, default: '0};

endpackage : sswd_pkg

/* sswd_top.sv */
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
// Behaviour
// - Mid-level activity input disables the watchdog
// - Stuck activity: flag low, reset one timeout
// - Flag stays low until next activity edge or supply loss
// - Undriven activity input keeps flag high
// - Low-supply flag follows threshold one clock later, no hold
// - Battery flag high while backup feeds output
// - Switch output between main and backup supply
// - Memory select passes outside reset and during the select grace
// - Select grace up to 15 us at reset
// - Timing source: internal or oscillator pin
// - Internal source: pin picks fast or slow
// - External source derives both periods from pin
// - Power-fail flag independent of everything else
// - Active-high reset is inverse of active-low
// - Reset held 200 ms after supply returns
// - Default 1.6 s watchdog, 200 ms reset
// - Fast mode: 100 ms, 1.6 s after reset
// - Any activity edge restarts watchdog timer
module sswd_top #(
  parameter int unsigned TICK_CYC = sswd_pkg::INT_TICK_CYC
) (
  // Clock, enable and reset
  input  wire logic                        clk,
  input  wire logic                        clk_en,
  input  wire logic                        rst_n,
  // Supervised pins
  input  wire sswd_pkg::sswd_pins_in_type  pin,
  output sswd_pkg::sswd_pins_out_type      pout,
  // Interrupt
  output logic                             irq,
  // AXI4-Lite write channels
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [3:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  output logic [1:0]                       s_axi_bresp,
  // AXI4-Lite read channels
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  input  wire logic [3:0]                  s_axi_araddr,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp
);

  ////////////////////////////////////////////////////////////////////////
  // Address decode, one-hot over the four registers, zero if unmapped
  function automatic logic [3:0] reg_sel(input logic [3:0] a);
    reg_sel = {a == sswd_pkg::OFS_IMASK, a == sswd_pkg::OFS_ISTAT,
               a == sswd_pkg::OFS_STAT, a == sswd_pkg::OFS_CTRL};
  endfunction : reg_sel

  sswd_pkg::sswd_regs_type q;        // Current state
  sswd_pkg::sswd_regs_type n;        // Next state
  logic                    tick;     // One timing tick
  logic                    act_edge; // Activity transition seen
  logic [14:0]             lim;      // Last tick of watchdog period
  logic                    wd_on;    // Watchdog armed
  logic                    rst_act;  // Reset asserted next cycle
  logic [2:0]              evt;      // Interrupt events
  logic [2:0]              clr;      // Write-1 clears
  logic [3:0]              wsel;     // Write target
  logic [3:0]              rsel;     // Read target

  ////////////////////////////////////////////////////////////////////////
  // Bus handshakes from state
  assign s_axi_awready = !q.aw_have && !q.bvalid;
  assign s_axi_wready  = !q.w_have && !q.bvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign wsel          = reg_sel(q.awaddr);
  assign rsel          = reg_sel(s_axi_araddr);

  // Pins from state
  assign pout.reset_n                 = q.rsto_n;
  assign pout.reset                   = !q.rsto_n;
  assign pout.low_supply_n            = q.low_n;
  assign pout.battery_on_flag         = q.batt;
  assign pout.switched_supply_out     = q.batt;
  assign pout.activity_timeout_flag_n = q.wdo_n;
  assign pout.powerfail_flag_n        = q.pf_n;
  assign pout.mem_sel_out_n           = q.ce_n;
  assign irq                          = |(q.ist & q.imask);

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    n        = q;
    tick     = 1'b0;
    act_edge = 1'b0;
    lim      = sswd_pkg::WD_INT_SLOW_LAST;
    wd_on    = 1'b0;
    rst_act  = 1'b0;
    evt      = '0;
    clr      = '0;
    // Tick source selection
    if (pin.timing_source_sel)
    begin
      // Internal oscillator prescaler
      tick  = (q.pre == 15'(TICK_CYC - 1));
      n.pre = tick ? '0 : q.pre + 15'h0001;
    end
    else
    begin
      // Rising edge of capacitor or clock waveform
      tick  = pin.timing_osc_pin && !q.osc_q;
      n.pre = '0;
    end
    n.osc_q = pin.timing_osc_pin;
    // Activity decode, mid level ignored
    act_edge = !pin.activity_mid && (pin.activity_lvl != q.act_q);
    if (!pin.activity_mid)
    begin
      n.act_q = pin.activity_lvl;
    end
    // Watchdog period choice
    if (!pin.timing_source_sel)
    begin
      lim = q.first ? sswd_pkg::WD_EXT_SLOW_LAST : sswd_pkg::WD_FAST_LAST;
    end
    else if (!pin.timing_osc_pin)
    begin
      lim = q.first ? sswd_pkg::WD_INT_SLOW_LAST : sswd_pkg::WD_FAST_LAST;
    end
    else
    begin
      lim = sswd_pkg::WD_INT_SLOW_LAST;
    end
    wd_on = q.wd_en && !pin.activity_mid;
    // Supervisor sequence
    case (q.st)
      sswd_pkg::ST_LOW:
      begin
        // Supply back: start the reset hold
        if (pin.supply_ok)
        begin
          n.st      = sswd_pkg::ST_HOLD;
          n.rst_cnt = '0;
        end
      end
      sswd_pkg::ST_HOLD:
      begin
        // Count reset ticks
        if (tick)
        begin
          n.rst_cnt = q.rst_cnt + 12'h001;
          if (q.rst_cnt == sswd_pkg::RST_LAST)
          begin
            n.st     = sswd_pkg::ST_RUN;
            n.wd_cnt = '0;
            n.first  = 1'b1;
          end
        end
      end
      sswd_pkg::ST_RUN:
      begin
        // Watchdog counting
        if (!wd_on || act_edge)
        begin
          n.wd_cnt = '0;
          if (act_edge)
          begin
            n.first = 1'b0;
          end
        end
        else if (tick)
        begin
          if (q.wd_cnt == lim)
          begin
            n.st      = sswd_pkg::ST_HOLD;
            n.rst_cnt = '0;
            n.wdo_n   = 1'b0;
            evt[sswd_pkg::EV_WD] = 1'b1;
          end
          else
          begin
            n.wd_cnt = q.wd_cnt + 15'h0001;
          end
        end
      end
      default:
      begin
        n.st = sswd_pkg::ST_LOW;
      end
    endcase
    // Supply loss overrides everything
    if (!pin.supply_ok)
    begin
      n.st = sswd_pkg::ST_LOW;
    end
    // Watchdog flag release
    if (act_edge || pin.activity_mid || !pin.supply_ok)
    begin
      n.wdo_n = 1'b1;
    end
    rst_act  = (n.st != sswd_pkg::ST_RUN);
    n.rsto_n = !rst_act;
    // Supply switchover with hold in the gap
    if (pin.main_above_backup && pin.supply_ok)
    begin
      n.batt = 1'b0;
    end
    else if (!pin.main_above_backup && !pin.supply_ok)
    begin
      n.batt = 1'b1;
    end
    // Select grace at reset entry
    if (rst_act && q.rsto_n && !pin.mem_sel_n)
    begin
      n.grace = 1'b1;
      n.gcnt  = '0;
    end
    else if (q.grace)
    begin
      if (pin.mem_sel_n || q.gcnt == sswd_pkg::CE_GRACE_LAST)
      begin
        n.grace = 1'b0;
      end
      n.gcnt = q.gcnt + 12'h001;
    end
    n.ce_n  = pin.mem_sel_n || (rst_act && !n.grace);
    n.low_n = pin.supply_ok;
    n.pf_n  = !pin.powerfail_below;
    evt[sswd_pkg::EV_SL] = q.low_n && !pin.supply_ok;
    evt[sswd_pkg::EV_PF] = q.pf_n && pin.powerfail_below;
    // Write address and data capture
    if (s_axi_awvalid && s_axi_awready)
    begin
      n.aw_have = 1'b1;
      n.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      n.w_have = 1'b1;
      n.wdata  = s_axi_wdata[7:0];
      n.wstrb0 = s_axi_wstrb[0];
    end
    // Write commit once both halves are held
    if (q.aw_have && q.w_have)
    begin
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = (wsel == '0) ? sswd_pkg::RESP_SLVERR : sswd_pkg::RESP_OKAY;
      if (q.wstrb0)
      begin
        if (wsel[0])
          n.wd_en = q.wdata[0];
        if (wsel[2])
          clr = q.wdata[2:0];
        if (wsel[3])
          n.imask = q.wdata[2:0];
      end
    end
    if (q.bvalid && s_axi_bready)
    begin
      n.bvalid = 1'b0;
    end
    // Sticky events, set beats clear
    n.ist = (q.ist & ~clr) | evt;
    // Read
    if (s_axi_arvalid && s_axi_arready)
    begin
      n.rvalid = 1'b1;
      n.rresp  = (rsel == '0) ? sswd_pkg::RESP_SLVERR : sswd_pkg::RESP_OKAY;
      n.rdata  = '0;
      if (rsel[0])
        n.rdata = {31'h0000_0000, q.wd_en};
      if (rsel[1])
        n.rdata = {25'h000_0000, q.st, q.wdo_n, q.batt, q.low_n, q.rsto_n};
      if (rsel[2])
        n.rdata = {29'h0000_0000, q.ist};
      if (rsel[3])
        n.rdata = {29'h0000_0000, q.imask};
    end
    else if (q.rvalid && s_axi_rready)
    begin
      n.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register, frozen while clk_en is low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= sswd_pkg::REGS_RST;
    end
    else if (clk_en)
    begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_mid_flag_high: assert property (clk_en && pin.activity_mid |=> pout.activity_timeout_flag_n)
    else $error("Flag low while activity input undriven");
  a_reset_inverse: assert property (pout.reset == !pout.reset_n)
    else $error("Reset outputs not inverse");
  a_low_supply: assert property ($past(clk_en) |-> pout.low_supply_n == $past(pin.supply_ok))
    else $error("Low-supply flag lags threshold");
  a_pf_flag: assert property ($past(clk_en) |-> pout.powerfail_flag_n == !$past(pin.powerfail_below))
    else $error("Power-fail flag mismatch");
  a_supply_hold: assert property ($rose(pin.supply_ok) |=> !pout.reset_n [*8])
    else $error("Reset released too soon after supply");
  a_wd_reset: assert property ($fell(pout.activity_timeout_flag_n) |-> !pout.reset_n)
    else $error("Watchdog flag fell without reset");
  a_ce_gate: assert property (!pout.mem_sel_out_n |-> !$past(pin.mem_sel_n))
    else $error("Gated select low without request");
  a_batt_flag: assert property (pout.battery_on_flag == pout.switched_supply_out)
    else $error("Battery flag disagrees with switch");
  a_grace_bound: assert property (q.grace |-> q.gcnt <= sswd_pkg::CE_GRACE_LAST)
    else $error("Select grace overran");
  a_irq_level: assert property (irq == |(q.ist & q.imask))
    else $error("Interrupt level mismatch");

endmodule : sswd_top

/* sswd_cpu_model.sv */
`timescale 1ns/1ns
module sswd_cpu_model (
  // Clock and resets
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cpu_reset_n,
  // Bench controls
  input  wire logic        run,
  input  wire logic        osc_run,
  input  wire logic [11:0] gap,
  // Lines toward the supervisor
  output logic             act,
  output logic             osc
);
  logic [11:0] cnt_q;  // Cycles since last toggle
  logic        act_q;  // Activity line level
  logic        osc_q;  // External timing clock level

  ////////////////////////////////////////////////////////////////////////
  // Processor toggles activity only while it runs out of reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 12'h000;
      act_q <= 1'b0;
    end
    else if (run && cpu_reset_n && cnt_q >= gap)
    begin
      cnt_q <= 12'h000;
      act_q <= ~act_q;
    end
    else
      cnt_q <= cnt_q + 12'h001;
  end

  // External clock, stands still while not in use
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      osc_q <= 1'b0;
    else if (osc_run)
      osc_q <= ~osc_q;
  end

  assign act = act_q;
  assign osc = osc_q;
endmodule : sswd_cpu_model

/* supply_supervisor_watchdog_tb_top.sv */
`timescale 1ns/1ns
module supply_supervisor_watchdog_tb_top;
  ////////////////////////////////////////////////////////////////////////
  // Signals
  logic                        clk = 1'b0;  // 250 MHz clock
  logic                        rst_n;       // Async reset
  logic                        run;         // Partner activity enable
  logic                        osc_run;     // Partner clock enable
  logic                        act;         // Partner activity line
  logic                        osc;         // Partner timing clock
  sswd_pkg::sswd_pins_in_type  pin_q;       // Bench-driven pins
  sswd_pkg::sswd_pins_in_type  pin_w;       // Pins with partner merged
  sswd_pkg::sswd_pins_out_type pout;        // Supervisor outputs
  logic                        irq;         // Interrupt
  logic                        ce;          // Clock enable to the supervisor
  logic [3:0]                  strb;        // Write strobes
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [3:0]  awaddr, araddr;              // Bus addresses
  logic [31:0] wdata, rdata, rd;            // Bus data
  logic [1:0]  bresp, rresp, rs;            // Bus responses
  int          error_cnt, cmp_count, n;     // Counters
  // Rows: {supply_ok, above_backup, pf_below, low_n, batt, pf_n}
  logic [5:0]  rows [5] = '{6'h03, 6'h1A, 6'h35, 6'h2C, 6'h03};

  always #2 clk = ~clk;

  // Merge partner lines into the pin bundle
  always_comb
  begin
    pin_w              = pin_q;
    pin_w.activity_lvl = act;
    if (!pin_q.timing_source_sel)
      pin_w.timing_osc_pin = osc;
  end

  sswd_top #(.TICK_CYC(4)) dut (
    .clk(clk), .clk_en(ce), .rst_n(rst_n), .pin(pin_w), .pout(pout), .irq(irq),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp));

  sswd_cpu_model cpu (.clk(clk), .rst_n(rst_n), .cpu_reset_n(pout.reset_n), .run(run),
    .osc_run(osc_run), .gap(12'h1F4), .act(act), .osc(osc));

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Window check of a cycle count
  task automatic rng(input int v, input int lo, input int hi);
    chk((v >= lo && v <= hi) ? lo : v, lo);
  endtask : rng

  // Edges until reset_n shows the wanted level
  task automatic wait_rst(input logic lvl, output int c);
    c = 0;
    while (pout.reset_n !== lvl && c < 20000)
    begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask : wait_rst

  // Count cycles with reset asserted
  task automatic lows(input int cyc, output int c);
    c = 0;
    repeat (cyc)
    begin
      @(posedge clk);
      #1;
      if (pout.reset_n !== 1'b1)
        c++;
    end
  endtask : lows

  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    logic       aw, w, dn, awr, wr, bv;
    logic [1:0] br;
    int   k;
    @(posedge clk);
    aw = 1'b1;
    w = 1'b1;
    dn = 1'b0;
    k = 0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!dn && k < 100)
    begin
      // Levels that stand at the coming rising edge
      @(negedge clk);
      awr = awready;
      wr = wready;
      bv = bvalid;
      br = bresp;
      @(posedge clk);
      k++;
      if (aw && awr)
      begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wr)
      begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
      if (bv)
      begin
        dn = 1'b1;
        chk(br, sswd_pkg::RESP_OKAY);
        bready <= 1'b0;
      end
    end
    chk(dn, 1'b1);
  endtask : axw

  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, dn, arr, rv;
    int   k;
    @(posedge clk);
    ar = 1'b1;
    dn = 1'b0;
    k = 0;
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!dn && k < 100)
    begin
      // Levels and read data that stand at the coming rising edge
      @(negedge clk);
      arr = arready;
      rv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      k++;
      if (ar && arr)
      begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
      if (rv)
      begin
        dn = 1'b1;
        rready <= 1'b0;
      end
    end
    chk(dn, 1'b1);
  endtask : axr

  task automatic print_verdict();
    $display("Counts: compares=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////
  // Watchdog against hangs, about twice the expected run
  initial
  begin
    #400000;
    error_cnt++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    {run, osc_run, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    pin_q = '0;
    pin_q.activity_mid = 1'b1;
    pin_q.timing_source_sel = 1'b1;
    pin_q.mem_sel_n = 1'b1;
    ce = 1'b1;
    strb = 4'hF;
    repeat (20) @(posedge clk);
    chk({pout.reset_n, pout.reset, pout.activity_timeout_flag_n}, 3'h3);
    chk({pout.mem_sel_out_n, irq}, 2'h2);
    rst_n <= 1'b1;
    $display("test reset done");
    // Supply, backup and power-fail table
    foreach (rows[i])
    begin
      {pin_q.supply_ok, pin_q.main_above_backup, pin_q.powerfail_below} <= rows[i][5:3];
      repeat (2) @(posedge clk);
      #1;
      chk({pout.low_supply_n, pout.battery_on_flag, pout.powerfail_flag_n}, rows[i][2:0]);
      chk(pout.switched_supply_out, rows[i][1]);
      chk(pout.reset_n, 1'b0);
      @(posedge clk);
    end
    $display("test table done");
    // Internal timing: reset hold after supply returns
    {pin_q.supply_ok, pin_q.main_above_backup, pin_q.powerfail_below} <= 3'h6;
    wait_rst(1'b1, n);
    rng(n, 8180, 8215);
    #1;
    chk({pout.reset, pout.activity_timeout_flag_n}, 2'h1);
    @(posedge clk);
    // External clock, activity undriven: no watchdog
    pin_q.timing_source_sel <= 1'b0;
    osc_run <= 1'b1;
    lows(10000, n);
    chk(n, 0);
    @(posedge clk);
    // Activity toggling keeps reset away; select passes
    pin_q.activity_mid <= 1'b0;
    pin_q.mem_sel_n <= 1'b0;
    run <= 1'b1;
    lows(10000, n);
    chk(n, 0);
    chk(pout.mem_sel_out_n, 1'b0);
    $display("test activity done");
    // Stop activity right after an edge: timeout, then select grace
    @(act);
    run <= 1'b0;
    wait_rst(1'b0, n);
    rng(n, 2030, 2075);
    #1;
    chk({pout.activity_timeout_flag_n, pout.mem_sel_out_n}, 2'h0);
    repeat (3700) @(posedge clk);
    #1;
    chk(pout.mem_sel_out_n, 1'b0);
    repeat (100) @(posedge clk);
    #1;
    chk(pout.mem_sel_out_n, 1'b1);
    wait_rst(1'b1, n);
    rng(n + 3800, 4070, 4120);
    #1;
    chk(pout.activity_timeout_flag_n, 1'b0);
    // No activity after reset: long period applies
    wait_rst(1'b0, n);
    rng(n, 8180, 8220);
    @(posedge clk);
    run <= 1'b1;
    wait_rst(1'b1, n);
    chk(pout.activity_timeout_flag_n, 1'b0);
    repeat (600) @(posedge clk);
    #1;
    chk(pout.activity_timeout_flag_n, 1'b1);
    $display("test timeout done");
    @(posedge clk);
    // Supply loss: grace cut short by select going high
    pin_q.supply_ok <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({pout.low_supply_n, pout.reset_n, pout.mem_sel_out_n}, 3'h0);
    @(posedge clk);
    pin_q.mem_sel_n <= 1'b1;
    repeat (2) @(posedge clk);
    pin_q.mem_sel_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(pout.mem_sel_out_n, 1'b1);
    $display("test supply loss done");
    // Clock enable low freezes the power-fail flag, high lets it follow again
    @(posedge clk);
    ce <= 1'b0;
    pin_q.powerfail_below <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(pout.powerfail_flag_n, 1'b1);
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(pout.powerfail_flag_n, 1'b0);
    $display("test freeze done");
    // Registers and interrupt
    axr(sswd_pkg::OFS_ISTAT, rd, rs);
    chk(rd, 32'h0000_0007);
    chk(irq, 1'b0);
    axr(sswd_pkg::OFS_STAT, rd, rs);
    chk(rd, 32'h0000_0018);
    axw(sswd_pkg::OFS_IMASK, 32'h0000_0001);
    #1;
    chk(irq, 1'b1);
    // Write with byte 0 strobe off leaves the mask alone
    @(posedge clk);
    strb <= 4'h0;
    axw(sswd_pkg::OFS_IMASK, 32'h0000_0000);
    #1;
    chk(irq, 1'b1);
    @(posedge clk);
    strb <= 4'hF;
    axw(sswd_pkg::OFS_ISTAT, 32'h0000_0001);
    #1;
    chk(irq, 1'b0);
    axr(sswd_pkg::OFS_ISTAT, rd, rs);
    chk(rd, 32'h0000_0006);
    axr(sswd_pkg::OFS_CTRL, rd, rs);
    chk(rs, sswd_pkg::RESP_OKAY);
    chk(rd, 32'h0000_0001);
    axr(4'h2, rd, rs);
    chk(rs, sswd_pkg::RESP_SLVERR);
    chk(rd, 32'h0000_0000);
    $display("test registers done");
    print_verdict();
  end
endmodule : supply_supervisor_watchdog_tb_top
